// File: src/ascff_top.v
/*
  angle sensor configuration, zero offset, direction, bias trim and field flags,
  with an spi slave (mode 0, 16-bit frames, msb first) for register access.
  assumes raw angle and field strength come from the front end on clk;
  spi pins are asynchronous and are sampled through two flip-flops.
*/
`timescale 1ns/1ps
`include "ascff_defs.vh"
module ascff_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // front end
  input  wire [15:0] raw_angle,
  input  wire [7:0]  field_mt,
  // spi pins
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,
  output reg         spi_miso_ff,
  output reg         spi_miso_oe_ff,
  // angle and trim to the front end
  output reg  [15:0] angle_out_ff,
  output reg  [7:0]  bias_trim_amount_ff,
  output reg         trim_x_enable_ff,
  output reg         trim_y_enable_ff,
  // field flag pins
  output reg         field_low_flag_ff,
  output reg         field_high_flag_ff
);
  // synchronisers
  reg  [1:0]  sclk_sync_ff;
  reg  [1:0]  cs_sync_ff;
  reg  [1:0]  mosi_sync_ff;
  reg         sclk_last_ff;
  // registers
  reg  [15:0] zero_ff;
  reg         dir_ff;
  reg  [7:0]  field_cfg_ff;
  // spi shifters
  reg  [15:0] rx_ff;
  reg  [15:0] tx_ff;
  reg  [4:0]  bits_ff;
  reg  [7:0]  pend_val_ff;
  reg         pend_full_ff;
  // state
  localparam  ST_IDLE = 2'b01;
  localparam  ST_XFER = 2'b10;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_act;
  wire [15:0] rx_word;
  wire [2:0]  cmd;
  wire [4:0]  addr;
  wire [15:0] nxt_angle;
  wire        low_flag;
  wire        high_flag;
  // frame decode
  wire        frame_start;
  wire        shift_in;
  wire        shift_out;
  wire        frame_done;
  wire        cmd_read;
  wire        cmd_write;
  wire [7:0]  reg_rdata;
  reg  [7:0]  nxt_pend_val;
  reg         nxt_pend_full;
  // register write strobes
  wire        wr_zero_lo;
  wire        wr_zero_hi;
  wire        wr_trim_amt;
  wire        wr_trim_axis;
  wire        wr_field_cfg;
  wire        wr_dir;

  function [7:0] ascff_read;
    input [4:0] a;
    begin
      case (a)
        `ASCFF_REG_ZERO_LO:   ascff_read = zero_ff[7:0];
        `ASCFF_REG_ZERO_HI:   ascff_read = zero_ff[15:8];
        `ASCFF_REG_TRIM_AMT:  ascff_read = bias_trim_amount_ff;
        `ASCFF_REG_TRIM_AXIS: ascff_read = {1'b0, trim_y_enable_ff, 5'h00, trim_x_enable_ff};
        `ASCFF_REG_FIELD_CFG: ascff_read = field_cfg_ff;
        `ASCFF_REG_DIR:       ascff_read = {dir_ff, 7'h00};
        `ASCFF_REG_FIELD_STS: ascff_read = {field_high_flag_ff, field_low_flag_ff, 6'h00};
        default:              ascff_read = 8'h00;
      endcase
    end
  endfunction

  // write strobe for one register address
  function ascff_hit;
    input       strobe;
    input [4:0] a;
    input [4:0] target;
    begin
      ascff_hit = strobe & (a == target);
    end
  endfunction

  // subtraction modulo one revolution
  function [15:0] ascff_sub;
    input [15:0] minuend;
    input [15:0] subtrahend;
    begin
      ascff_sub = minuend - subtrahend;
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_ff <= 2'h0;
      cs_sync_ff   <= `ASCFF_CS_IDLE;
      mosi_sync_ff <= 2'h0;
      sclk_last_ff <= 1'b0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], spi_sclk};
      cs_sync_ff   <= {cs_sync_ff[0], spi_cs_n};
      mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
      sclk_last_ff <= sclk_sync_ff[1];
    end
  end

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_last_ff;
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_last_ff;
  assign cs_act    = ~cs_sync_ff[1];
  assign rx_word   = {rx_ff[14:0], mosi_sync_ff[1]};
  assign cmd       = rx_word[15:13];
  assign addr      = rx_word[12:8];

  // angle path
  assign nxt_angle = dir_ff ? ascff_sub(zero_ff, raw_angle)
                            : ascff_sub(raw_angle, zero_ff);

  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = cs_act ? ST_XFER : ST_IDLE;
      ST_XFER: nxt_state = cs_act ? ST_XFER : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // frame decode
  assign frame_start = (state_ff == ST_IDLE) & cs_act;
  assign shift_in    = (state_ff == ST_XFER) & cs_act & sclk_rise;
  assign shift_out   = (state_ff == ST_XFER) & cs_act & sclk_fall;
  assign frame_done  = shift_in & (bits_ff == `ASCFF_FRAME_LAST);
  assign cmd_read    = frame_done & (cmd == `ASCFF_CMD_RD_REG);
  assign cmd_write   = frame_done & (cmd == `ASCFF_CMD_WR_REG);
  assign reg_rdata   = ascff_read(addr);

  // register write strobes
  assign wr_zero_lo   = ascff_hit(cmd_write, addr, `ASCFF_REG_ZERO_LO);
  assign wr_zero_hi   = ascff_hit(cmd_write, addr, `ASCFF_REG_ZERO_HI);
  assign wr_trim_amt  = ascff_hit(cmd_write, addr, `ASCFF_REG_TRIM_AMT);
  assign wr_trim_axis = ascff_hit(cmd_write, addr, `ASCFF_REG_TRIM_AXIS);
  assign wr_field_cfg = ascff_hit(cmd_write, addr, `ASCFF_REG_FIELD_CFG);
  assign wr_dir       = ascff_hit(cmd_write, addr, `ASCFF_REG_DIR);

  // spi shifter and miso
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff       <= ST_IDLE;
      rx_ff          <= `ASCFF_RST_WORD;
      tx_ff          <= `ASCFF_RST_WORD;
      bits_ff        <= `ASCFF_RST_BITS;
      spi_miso_ff    <= 1'b0;
      spi_miso_oe_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      spi_miso_oe_ff <= cs_act;
      if (frame_start) begin
        // reply word: angle byte plus pending value, or full angle
        bits_ff     <= `ASCFF_RST_BITS;
        tx_ff       <= pend_full_ff ? {angle_out_ff[15:8], pend_val_ff}
                                    : angle_out_ff;
        spi_miso_ff <= angle_out_ff[15];
      end else begin
        if (shift_in) begin
          rx_ff   <= rx_word;
          bits_ff <= bits_ff + `ASCFF_BIT_STEP;
        end
        if (shift_out) begin
          tx_ff       <= {tx_ff[14:0], 1'b0};
          spi_miso_ff <= tx_ff[14];
        end
      end
    end
  end

  // reply value held for the next frame
  always @* begin
    nxt_pend_val  = pend_val_ff;
    nxt_pend_full = pend_full_ff;
    if (frame_start) begin
      nxt_pend_full = 1'b0;
    end else if (cmd_read) begin
      nxt_pend_val  = reg_rdata;
      nxt_pend_full = 1'b1;
    end else if (cmd_write) begin
      nxt_pend_val  = rx_word[7:0];
      nxt_pend_full = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_val_ff  <= `ASCFF_RST_ZERO;
      pend_full_ff <= 1'b0;
    end else begin
      pend_val_ff  <= nxt_pend_val;
      pend_full_ff <= nxt_pend_full;
    end
  end

  // zero position
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_ff <= {`ASCFF_RST_ZERO, `ASCFF_RST_ZERO};
    end else begin
      if (wr_zero_lo) zero_ff[7:0] <= rx_word[7:0];
      if (wr_zero_hi) zero_ff[15:8] <= rx_word[7:0];
    end
  end

  // rotation direction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= 1'b0;
    end else if (wr_dir) begin
      dir_ff <= rx_word[`ASCFF_BIT_DIR];
    end
  end

  // bias trim amount
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_trim_amount_ff <= `ASCFF_RST_ZERO;
    end else if (wr_trim_amt) begin
      bias_trim_amount_ff <= rx_word[7:0];
    end
  end

  // bias trim axis enables
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_x_enable_ff <= 1'b0;
      trim_y_enable_ff <= 1'b0;
    end else if (wr_trim_axis) begin
      trim_x_enable_ff <= rx_word[`ASCFF_BIT_TRIM_X];
      trim_y_enable_ff <= rx_word[`ASCFF_BIT_TRIM_Y];
    end
  end

  // field threshold configuration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_cfg_ff <= `ASCFF_RST_FIELD_CFG;
    end else if (wr_field_cfg) begin
      field_cfg_ff <= rx_word[7:0];
    end
  end

  // output angle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      angle_out_ff <= `ASCFF_RST_WORD;
    end else begin
      angle_out_ff <= nxt_angle;
    end
  end

  // field flags
  ascff_field_cmp u_low (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (field_cfg_ff[`ASCFF_BIT_CHK_EN]),
    .above_mode (1'b0),
    .code       (field_cfg_ff[`ASCFF_LOW_MSB:`ASCFF_LOW_LSB]),
    .field_mt   (field_mt),
    .flag_ff    (low_flag)
  );

  ascff_field_cmp u_high (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (field_cfg_ff[`ASCFF_BIT_CHK_EN]),
    .above_mode (1'b1),
    .code       (field_cfg_ff[`ASCFF_HIGH_MSB:`ASCFF_HIGH_LSB]),
    .field_mt   (field_mt),
    .flag_ff    (high_flag)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_low_flag_ff  <= 1'b0;
      field_high_flag_ff <= 1'b0;
    end else begin
      field_low_flag_ff  <= low_flag;
      field_high_flag_ff <= high_flag;
    end
  end
endmodule

// File: src/ascff_defs.vh
/*
  constants for the angle sensor configuration and field flag block.
  assumes inclusion by the design files only; definitions only.
*/
`ifndef ASCFF_DEFS_VH
`define ASCFF_DEFS_VH
`define ASCFF_REG_ZERO_LO   5'h00
`define ASCFF_REG_ZERO_HI   5'h01
`define ASCFF_REG_TRIM_AMT  5'h02
`define ASCFF_REG_TRIM_AXIS 5'h03
`define ASCFF_REG_FIELD_CFG 5'h06
`define ASCFF_REG_DIR       5'h09
`define ASCFF_REG_FIELD_STS 5'h1B
`define ASCFF_CMD_RD_ANGLE  3'h0
`define ASCFF_CMD_RD_REG    3'h2
`define ASCFF_CMD_WR_REG    3'h4
`define ASCFF_RST_FIELD_CFG 8'h1D
`define ASCFF_RST_ZERO      8'h00
`define ASCFF_BIT_DIR       7
`define ASCFF_BIT_TRIM_Y    6
`define ASCFF_BIT_TRIM_X    0
`define ASCFF_BIT_CHK_EN    0
`define ASCFF_LOW_MSB       7
`define ASCFF_LOW_LSB       5
`define ASCFF_HIGH_MSB      4
`define ASCFF_HIGH_LSB      2
`define ASCFF_STS_HIGH      7
`define ASCFF_STS_LOW       6
`define ASCFF_TRIP_BASE     8'h1A
`define ASCFF_TRIP_1        8'h29
`define ASCFF_TRIP_2        8'h38
`define ASCFF_TRIP_3        8'h46
`define ASCFF_TRIP_4        8'h54
`define ASCFF_TRIP_5        8'h62
`define ASCFF_TRIP_6        8'h70
`define ASCFF_TRIP_7        8'h7E
`define ASCFF_TRIP_HYST     8'h06
`define ASCFF_FRAME_LAST    5'h0F
`define ASCFF_BIT_STEP      5'h01
`define ASCFF_RST_BITS      5'h00
`define ASCFF_RST_WORD      16'h0000
`define ASCFF_CS_IDLE       2'h3
`endif

// File: src/ascff_field_cmp.v
/*
  field strength comparator with hysteresis for one threshold code.
  assumes field strength in mT on the same clock as the caller.
*/
`timescale 1ns/1ps
`include "ascff_defs.vh"
module ascff_field_cmp (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire       enable,
  input  wire       above_mode,
  input  wire [2:0] code,
  input  wire [7:0] field_mt,
  // flag
  output reg        flag_ff
);
  reg  [7:0] rise_pt;
  reg  [7:0] fall_pt;
  reg        nxt_flag;

  // rising trip points 26..126 mT, falling 6 mT lower
  function [7:0] ascff_rise;
    input [2:0] c;
    begin
      case (c)
        3'h0: ascff_rise = `ASCFF_TRIP_BASE;
        3'h1: ascff_rise = `ASCFF_TRIP_1;
        3'h2: ascff_rise = `ASCFF_TRIP_2;
        3'h3: ascff_rise = `ASCFF_TRIP_3;
        3'h4: ascff_rise = `ASCFF_TRIP_4;
        3'h5: ascff_rise = `ASCFF_TRIP_5;
        3'h6: ascff_rise = `ASCFF_TRIP_6;
        default: ascff_rise = `ASCFF_TRIP_7;
      endcase
    end
  endfunction

  always @* begin
    rise_pt = ascff_rise(code);
    fall_pt = rise_pt - `ASCFF_TRIP_HYST;
    nxt_flag = flag_ff;
    if (!enable) begin
      nxt_flag = 1'b0;
    end else if (above_mode) begin
      if (field_mt > rise_pt) nxt_flag = 1'b1;
      else if (field_mt < fall_pt) nxt_flag = 1'b0;
    end else begin
      if (field_mt < fall_pt) nxt_flag = 1'b1;
      else if (field_mt > rise_pt) nxt_flag = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) flag_ff <= 1'b0;
    else flag_ff <= nxt_flag;
  end
endmodule

// File: tb/ascff_monitor.sv
/* assertions on the top ports of the sensor block.
   assumes a bind into ascff_top, one clock domain. */
`timescale 1ns/1ps
module ascff_monitor (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // inputs seen
  input wire [15:0] raw_angle,
  input wire [7:0]  field_mt,
  input wire        spi_cs_n,
  // outputs seen
  input wire        spi_miso_oe_ff,
  input wire [15:0] angle_out_ff,
  input wire [7:0]  bias_trim_amount_ff,
  input wire        trim_x_enable_ff,
  input wire        trim_y_enable_ff,
  input wire        field_low_flag_ff,
  input wire        field_high_flag_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe_on; $fell(spi_cs_n) |-> ##[2:6] spi_miso_oe_ff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso enable late");
  property p_oe_off; $rose(spi_cs_n) |-> ##[2:6] !spi_miso_oe_ff; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso enable stuck");
  property p_high_rise; $rose(field_high_flag_ff) |-> $past(field_mt, 2) > 8'h1A; endproperty
  a_high_rise: assert property (p_high_rise) else $error("high flag too low");
  property p_low_rise; $rose(field_low_flag_ff) |-> $past(field_mt, 2) < 8'h78; endproperty
  a_low_rise: assert property (p_low_rise) else $error("low flag too high");
  property p_trim; spi_cs_n [*8] |=> $stable(bias_trim_amount_ff); endproperty
  a_trim: assert property (p_trim) else $error("trim moved idle");
  property p_axis; spi_cs_n [*8] |=> $stable({trim_x_enable_ff, trim_y_enable_ff}); endproperty
  a_axis: assert property (p_axis) else $error("axis moved idle");
  property p_angle; (spi_cs_n && $stable(raw_angle)) [*8] |=> $stable(angle_out_ff); endproperty
  a_angle: assert property (p_angle) else $error("angle moved");
  property p_flags; (spi_cs_n && $stable(field_mt)) [*6] |=> $stable(field_low_flag_ff); endproperty
  a_flags: assert property (p_flags) else $error("low flag moved");
endmodule

// File: tb/ascff_spi_ctrl.sv
/* spi controller model, mode 0, 16-bit frames, msb first.
   assumes the device samples sclk with its own clock. */
`timescale 1ns/1ps
module ascff_spi_ctrl (
  // clock
  input  wire  clk,
  // spi pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  wire  miso
);
  // clk cycles per sclk half period, 64 ns sclk period
  int half = 8;
  initial begin
    sclk <= 1'b0;
    cs_n <= 1'b1;
    mosi <= 1'b0;
  end
  // one frame; a command's reply needs a further frame
  // pins move by nba on clk edges; miso taken at the sclk rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (half) @(posedge clk);
      sclk  <= 1'b1;
      rx[i] = miso;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
endmodule

// File: tb/tb_ascff_top.sv
/* self-checking bench for the angle sensor configuration block.
   assumes the controller model and the monitor are compiled first. */
`timescale 1ns/1ps
module tb_ascff_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] raw_angle = 16'h0000;
  logic [7:0]  field_mt = 8'h3C;
  wire         sclk, cs_n, mosi, miso, oe, xe, ye, lf, hf;
  wire         miso_pin;
  wire  [15:0] ang;
  wire  [7:0]  trim;
  logic [15:0] rx;
  logic [7:0]  v;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  rise [8] = '{8'h1A, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7E};
  int          off [5] = '{-7, 0, 1, -6, -7};
  logic [1:0]  exp_hl [5] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b01};
  ascff_top uut (.clk(clk), .rst_n(rst_n), .raw_angle(raw_angle), .field_mt(field_mt),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_ff(miso), .spi_miso_oe_ff(oe),
    .angle_out_ff(ang), .bias_trim_amount_ff(trim), .trim_x_enable_ff(xe), .trim_y_enable_ff(ye),
    .field_low_flag_ff(lf), .field_high_flag_ff(hf));
  // released miso shows the inverse, so a bit taken while undriven is caught
  assign miso_pin = oe ? miso : ~miso;
  ascff_spi_ctrl ctl (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_pin));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    ctl.xfer({3'b100, a, d}, rx);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    ctl.xfer({3'b010, a, 8'h00}, rx);
    ctl.xfer(16'h0000, rx);
    d = rx[7:0];
  endtask
  task automatic setf(input logic [7:0] f);
    @(posedge clk) field_mt <= f;
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(5'h06, v);
    chk("cfg reset", 16'h001D, v);
    for (int c = 0; c < 8; c++) begin
      wr(5'h06, {c[2:0], c[2:0], 2'b01});
      for (int r = 0; r < 5; r++) begin
        setf(8'(int'(rise[c]) + off[r]));
        chk("flag pins", exp_hl[r], {hf, lf});
        rd(5'h1B, v);
        chk("flag status", exp_hl[r], v[7:6]);
      end
    end
    wr(5'h06, 8'hE1);
    setf(8'd100);
    chk("both flags", 16'h0003, {hf, lf});
    rd(5'h06, v);
    chk("cfg kept", 16'h00E1, v);
    wr(5'h06, 8'hE0);
    setf(8'd100);
    chk("flags off", 16'h0000, {hf, lf});
    @(posedge clk) raw_angle <= 16'h0010;
    wr(5'h00, 8'hFF);
    wr(5'h01, 8'hFF);
    chk("angle cw", 16'h0011, ang);
    wr(5'h09, 8'h80);
    chk("angle ccw", 16'hFFEF, ang);
    rd(5'h09, v);
    chk("reply angle", 16'h00FF, rx[15:8]);
    chk("dir read", 16'h0080, v);
    wr(5'h02, 8'h81);
    chk("full angle", 16'hFFEF, rx);
    wr(5'h03, 8'h41);
    chk("trim amount", 16'h0081, trim);
    chk("trim both", 16'h0003, {xe, ye});
    wr(5'h03, 8'h01);
    chk("trim x only", 16'h0002, {xe, ye});
    rd(5'h1F, v);
    chk("unmapped", 16'h0000, v);
    @(posedge clk) rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("trim reset", 16'h0000, trim);
    chk("pins reset", 16'h0000, {oe, hf, lf});
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(5'h06, v);
    chk("cfg reset again", 16'h001D, v);
    results();
  end
endmodule
bind ascff_top ascff_monitor mon (.clk(clk), .rst_n(rst_n), .raw_angle(raw_angle),
  .field_mt(field_mt), .spi_cs_n(spi_cs_n), .spi_miso_oe_ff(spi_miso_oe_ff),
  .angle_out_ff(angle_out_ff), .bias_trim_amount_ff(bias_trim_amount_ff),
  .trim_x_enable_ff(trim_x_enable_ff), .trim_y_enable_ff(trim_y_enable_ff),
  .field_low_flag_ff(field_low_flag_ff), .field_high_flag_ff(field_high_flag_ff));
